// ===== src/ppe_encoder.sv
/*
  Registered 8b/10b encoder with control/data select, forced starting
  disparity and compliance disparity. One word per clock.
  Assumes inputs synchronous to clk_sys_in and an already synced reset.
*/
`include "ppe_params.svh"

module ppe_encoder (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire ppe_pkg::ppe_tx_s tx_in,
  output logic [`PPE_WORD_W-1:0] word_out,
  output logic rd_neg_out
);
  import ppe_pkg::*;

  logic rd_neg_reg;
  logic [`PPE_WORD_W-1:0] word_reg;
  wire [4:0] x5 = tx_in.data[4:0];
  wire [2:0] y3 = tx_in.data[7:5];
  // starting disparity: compliance forces negative, else a forced value wins over running disparity
  wire start_neg = tx_in.compliance ? 1'b1 : (tx_in.force_disp ? tx_in.disp_val : rd_neg_reg);
  logic [5:0] b6;
  logic [3:0] b4;
  logic b6_bal;
  logic b4_bal;
  logic mid_neg;
  logic alt7;

  // 5b/6b table, rd-negative form; balanced codes other than D.7 do not flip
  always_comb begin
    b6 = 6'h00;
    unique case (x5)
      5'h00: b6 = 6'h27; 5'h01: b6 = 6'h1D; 5'h02: b6 = 6'h2D; 5'h03: b6 = 6'h31;
      5'h04: b6 = 6'h35; 5'h05: b6 = 6'h29; 5'h06: b6 = 6'h19; 5'h07: b6 = 6'h38;
      5'h08: b6 = 6'h39; 5'h09: b6 = 6'h25; 5'h0A: b6 = 6'h15; 5'h0B: b6 = 6'h34;
      5'h0C: b6 = 6'h0D; 5'h0D: b6 = 6'h2C; 5'h0E: b6 = 6'h1C; 5'h0F: b6 = 6'h17;
      5'h10: b6 = 6'h1B; 5'h11: b6 = 6'h23; 5'h12: b6 = 6'h13; 5'h13: b6 = 6'h32;
      5'h14: b6 = 6'h0B; 5'h15: b6 = 6'h2A; 5'h16: b6 = 6'h1A; 5'h17: b6 = 6'h3A;
      5'h18: b6 = 6'h33; 5'h19: b6 = 6'h26; 5'h1A: b6 = 6'h16; 5'h1B: b6 = 6'h36;
      5'h1C: b6 = 6'h0E; 5'h1D: b6 = 6'h2E; 5'h1E: b6 = 6'h1E; 5'h1F: b6 = 6'h2B;
    endcase
    if (tx_in.ctrl && x5 == 5'h1C) begin
      b6 = 6'h0F;
    end
  end

  always_comb begin
    b6_bal = ($countones(b6) == 3);
    mid_neg = b6_bal ? start_neg : !start_neg;
    alt7 = tx_in.ctrl ||
      (mid_neg ? (x5 == 5'h11 || x5 == 5'h12 || x5 == 5'h14) : (x5 == 5'h0B || x5 == 5'h0D || x5 == 5'h0E));
    b4 = 4'h0;
    unique case (y3)
      3'h0: b4 = 4'hB; 3'h1: b4 = 4'h9; 3'h2: b4 = 4'h5; 3'h3: b4 = 4'hC;
      3'h4: b4 = 4'hD; 3'h5: b4 = 4'hA; 3'h6: b4 = 4'h6; 3'h7: b4 = alt7 ? 4'h7 : 4'hE;
    endcase
    if (tx_in.ctrl && (y3 == 3'h1 || y3 == 3'h2 || y3 == 3'h5 || y3 == 3'h6)) begin
      b4 = ~b4;
    end
    b4_bal = ($countones(b4) == 2);
  end

  // D.7 and x.3 are neutral yet have two forms; K codes always follow running disparity in the 4b group, balanced K 6b groups are kept
  wire b6_keep = b6_bal && !(x5 == 5'h07 && !tx_in.ctrl);
  wire b4_keep = b4_bal && (y3 != 3'h3) && !tx_in.ctrl;
  wire [5:0] b6_out = (start_neg || b6_keep) ? b6 : ~b6;
  wire [3:0] b4_out = (mid_neg || b4_keep) ? b4 : ~b4;
  wire end_neg = b4_bal ? mid_neg : !mid_neg;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_neg_reg <= 1'b1;
      word_reg <= `PPE_IDLE_WORD;
    end else begin
      rd_neg_reg <= end_neg;
      word_reg <= {b6_out, b4_out};
    end
  end

  assign word_out = word_reg;
  assign rd_neg_out = rd_neg_reg;
endmodule

// ===== src/ppe_params.svh
/*
  Timing counts, code points and field widths for the PHY control block.
  Assumes it is included by bare name into the package and the design modules.
*/
`ifndef PPE_PARAMS_SVH
`define PPE_PARAMS_SVH

`define PPE_CLK_MHZ 25
`define PPE_DET_TIME_NS 1000
`define PPE_DET_CYCLES ((`PPE_DET_TIME_NS * `PPE_CLK_MHZ) / 1000)
`define PPE_PWR_TIME_NS 400
`define PPE_PWR_CYCLES ((`PPE_PWR_TIME_NS * `PPE_CLK_MHZ) / 1000)
`define PPE_CNT_W 8
`define PPE_RECFG_W 4
`define PPE_SLIP_W 4
`define PPE_SLIP_MAX 4'h9
`define PPE_WORD_W 10
`define PPE_BYTE_W 8

`define PPE_PD_P0 2'h0
`define PPE_PD_P0S 2'h1
`define PPE_PD_P1 2'h2
`define PPE_PD_P2 2'h3

`define PPE_RS_OK 3'h0
`define PPE_RS_SKP_ADD 3'h1
`define PPE_RS_SKP_DEL 3'h2
`define PPE_RS_RX_DET 3'h3
`define PPE_RS_DEC_ERR 3'h4
`define PPE_RS_OVFL 3'h5
`define PPE_RS_UNFL 3'h6
`define PPE_RS_DISP_ERR 3'h7

`define PPE_K28_5 8'hBC
`define PPE_IDLE_WORD 10'h000

`endif

// ===== src/ppe_phy_ctrl.sv
/*
  Per-channel transceiver control: transmit encoder path and PIPE-style
  PHY controls (power states, receiver detect, loopback, electrical idle,
  receive status and valid). All ports but rst_n_in synchronous to clk_sys_in; the reset is synchronized inside.
  Assumes analog blocks (receiver detect comparator, signal detect, idle
  inference, elastic buffer, decoder) report their results on plain inputs.
*/
`include "ppe_params.svh"

module ppe_phy_ctrl (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire ppe_pkg::ppe_tx_s tx_in,
  input wire logic [`PPE_SLIP_W-1:0] tx_slip_in,
  input wire logic tx_invert_in,
  input wire logic pcie_mode_in,
  input wire logic receive_polarity_invert_in,
  input wire logic [1:0] power_state_in,
  input wire logic detect_loop_in,
  input wire logic force_idle_in,
  input wire logic infer_en_in,
  input wire logic infer_idle_in,
  input wire logic signal_detect_in,
  input wire logic rx_present_in,
  input wire logic [`PPE_WORD_W-1:0] rx_word_in,
  input wire ppe_pkg::ppe_rx_s rx_dec_in,
  input wire logic rx_dec_valid_in,
  input wire logic skip_add_in,
  input wire logic skip_del_in,
  input wire logic ebuf_ovfl_in,
  input wire logic ebuf_unfl_in,
  input wire logic [`PPE_RECFG_W-1:0] reconfig_cmd_in,
  output logic [`PPE_WORD_W-1:0] tx_word_out,
  output logic tx_elec_idle_out,
  output logic rx_detect_active_out,
  output logic loopback_out,
  output logic [`PPE_WORD_W-1:0] rx_dec_word_out,
  output logic offset_cal_fixed_out,
  output logic [`PPE_RECFG_W-1:0] reconfig_out,
  output logic rx_elec_idle_out,
  output logic phy_status_out,
  output ppe_pkg::ppe_rxstat_t rx_status_out,
  output ppe_pkg::ppe_rx_s rx_data_out,
  output logic rx_valid_out
);
  import ppe_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_DETECT, ST_PWR} ppe_st_e;

  logic rst_s1_reg;
  logic rst_s2_reg;
  wire rst_n = rst_s2_reg;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  // transmit path
  logic [`PPE_WORD_W-1:0] enc_word;
  ppe_encoder u_enc (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n),
    .tx_in(tx_in),
    .word_out(enc_word),
    .rd_neg_out()
  );

  logic force_idle_reg;
  ppe_slipper u_slip (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n),
    .word_in(enc_word),
    .slip_in(tx_slip_in),
    .invert_in(tx_invert_in),
    .idle_in(force_idle_reg),
    .word_out(tx_word_out)
  );

  // power and detect control
  ppe_pwr_e pwr_reg;
  ppe_st_e st_reg;
  ppe_st_e st_next;
  logic [`PPE_CNT_W-1:0] cnt_reg;
  logic [`PPE_CNT_W-1:0] cnt_next;
  logic det_prev_reg;
  logic det_result_reg;
  logic phy_status_reg;
  logic loop_reg;
  logic det_active_reg;

  wire ppe_pwr_e pwr_req = ppe_pwr_e'(power_state_in);
  wire det_rise = detect_loop_in && !det_prev_reg;
  wire det_start = det_rise && pwr_reg == PPE_P1 && force_idle_in && st_reg == ST_IDLE;
  wire pwr_change = pwr_req != pwr_reg && st_reg == ST_IDLE;
  wire cnt_done = cnt_reg == `PPE_CNT_W'(1);
  wire finish = st_reg != ST_IDLE && cnt_done;
  wire det_end = st_reg == ST_DETECT && cnt_done;

  always_comb begin
    st_next = st_reg;
    cnt_next = (cnt_reg != '0) ? cnt_reg - `PPE_CNT_W'(1) : cnt_reg;
    unique case (st_reg)
      ST_IDLE: begin
        if (det_start) begin
          st_next = ST_DETECT;
          cnt_next = `PPE_CNT_W'(`PPE_DET_CYCLES);
        end else if (pwr_change) begin
          st_next = ST_PWR;
          cnt_next = `PPE_CNT_W'(`PPE_PWR_CYCLES);
        end
      end
      ST_DETECT, ST_PWR: begin
        if (cnt_done) begin
          st_next = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ST_IDLE;
      cnt_reg <= '0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
    end
  end

  // a request that collides with a detect start waits for the next idle cycle
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      pwr_reg <= PPE_P2;
      det_prev_reg <= 1'b0;
    end else begin
      det_prev_reg <= detect_loop_in;
      if (pwr_change && !det_start) begin
        pwr_reg <= pwr_req;
      end
    end
  end

  // result holds until the controller drops detect, then status falls back
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      det_result_reg <= 1'b0;
    end else if (det_end) begin
      det_result_reg <= rx_present_in;
    end else if (!detect_loop_in) begin
      det_result_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      phy_status_reg <= 1'b0;
      loop_reg <= 1'b0;
      det_active_reg <= 1'b0;
      force_idle_reg <= 1'b1;
    end else begin
      phy_status_reg <= finish;
      det_active_reg <= st_next == ST_DETECT;
      loop_reg <= detect_loop_in && pwr_reg == PPE_P0 && !force_idle_in;
      force_idle_reg <= force_idle_in;
    end
  end

  assign phy_status_out = phy_status_reg;
  assign loopback_out = loop_reg;
  assign rx_detect_active_out = det_active_reg;
  assign tx_elec_idle_out = force_idle_reg;

  // receive side
  wire [`PPE_WORD_W-1:0] rx_pol = (pcie_mode_in && receive_polarity_invert_in) ? ~rx_word_in : rx_word_in;
  wire idle_ind = infer_en_in ? infer_idle_in : !signal_detect_in;
  // detect result wins so the controller sees it with the status pulse
  wire ppe_rxstat_t stat_sel =
    (det_result_reg || (det_end && rx_present_in)) ? `PPE_RS_RX_DET :
    rx_dec_in.code_err ? `PPE_RS_DEC_ERR :
    ebuf_ovfl_in ? `PPE_RS_OVFL :
    ebuf_unfl_in ? `PPE_RS_UNFL :
    rx_dec_in.disp_err ? `PPE_RS_DISP_ERR :
    skip_add_in ? `PPE_RS_SKP_ADD :
    skip_del_in ? `PPE_RS_SKP_DEL : `PPE_RS_OK;

  logic [`PPE_WORD_W-1:0] rx_word_reg;
  logic idle_reg;
  ppe_rxstat_t stat_reg;
  ppe_rx_s rx_reg;
  logic valid_reg;
  logic offset_reg;
  logic [`PPE_RECFG_W-1:0] recfg_reg;

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      rx_word_reg <= `PPE_IDLE_WORD;
      idle_reg <= 1'b1;
      stat_reg <= `PPE_RS_OK;
    end else begin
      rx_word_reg <= rx_pol;
      idle_reg <= idle_ind;
      stat_reg <= stat_sel;
    end
  end

  // data keeps its last valid word so a late reader still sees it
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      rx_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      rx_reg <= rx_dec_valid_in ? rx_dec_in : rx_reg;
      valid_reg <= rx_dec_valid_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      offset_reg <= 1'b0;
      recfg_reg <= '0;
    end else begin
      offset_reg <= pcie_mode_in;
      recfg_reg <= reconfig_cmd_in;
    end
  end

  assign rx_dec_word_out = rx_word_reg;
  assign rx_elec_idle_out = idle_reg;
  assign rx_status_out = stat_reg;
  assign rx_data_out = rx_reg;
  assign rx_valid_out = valid_reg;
  assign offset_cal_fixed_out = offset_reg;
  assign reconfig_out = recfg_reg;

  a_status_one_cycle: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    phy_status_out |=> !phy_status_out) else $error("phy status longer than one cycle");
  sequence s_det_go;
    det_start ##1 (st_reg == ST_DETECT);
  endsequence
  a_detect_done: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    s_det_go |-> ##[1:30] phy_status_out) else $error("detect never completed");
  a_loop_select: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (detect_loop_in && pwr_reg == PPE_P0 && !force_idle_in) |=> loopback_out) else $error("loopback missing");
  a_idle_infer: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    infer_en_in |=> rx_elec_idle_out == $past(infer_idle_in)) else $error("inferred idle wrong");
  a_idle_sigdet: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    !infer_en_in |=> rx_elec_idle_out == !$past(signal_detect_in)) else $error("idle not inverse of detect");
  a_tx_idle: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    force_idle_in ##1 force_idle_in |=> tx_word_out == `PPE_IDLE_WORD) else $error("tx not idle");
  a_rx_invert: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (pcie_mode_in && receive_polarity_invert_in) |=> rx_dec_word_out == ~$past(rx_word_in))
    else $error("rx polarity not inverted");
  a_valid_follow: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    rx_valid_out == $past(rx_dec_valid_in)) else $error("valid misaligned");
  a_det_status: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (st_reg == ST_DETECT && cnt_done && rx_present_in) |=> ##1 rx_status_out == `PPE_RS_RX_DET)
    else $error("receiver detected code missing");
  sequence s_pwr_go;
    (st_reg == ST_IDLE && pwr_req != pwr_reg && !det_start) ##1 (st_reg == ST_PWR);
  endsequence
  a_pwr_done: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    s_pwr_go |-> ##[1:20] phy_status_out) else $error("power change never completed");
  a_det_report: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (det_end && rx_present_in) |=> (phy_status_out && rx_status_out == `PPE_RS_RX_DET))
    else $error("detect result not with status pulse");
  a_status_source: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    phy_status_out |-> $past(st_reg) != ST_IDLE) else $error("status pulse without a phy function");
  a_det_active: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    s_det_go |-> rx_detect_active_out) else $error("detect active missing");
  a_offset_mode: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    !pcie_mode_in |=> !offset_cal_fixed_out) else $error("fixed clock used outside pcie");
  a_dec_err_prio: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (rx_dec_in.code_err && !det_result_reg && !det_end) |=> rx_status_out == `PPE_RS_DEC_ERR)
    else $error("decode error code missing");
  a_rx_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    !rx_dec_valid_in |=> $stable(rx_data_out)) else $error("receive data changed without valid");
endmodule

// ===== src/ppe_pkg.sv
/*
  Types shared by the PHY control block: power states, status codes and
  the packed carriers for transmit controls and receive results.
  Assumes ppe_params.svh is on the include path.
*/
`include "ppe_params.svh"

package ppe_pkg;

  typedef enum logic [1:0] {
    PPE_P0 = `PPE_PD_P0,
    PPE_P0S = `PPE_PD_P0S,
    PPE_P1 = `PPE_PD_P1,
    PPE_P2 = `PPE_PD_P2
  } ppe_pwr_e;

  typedef logic [2:0] ppe_rxstat_t;

  typedef struct packed {
    logic [`PPE_BYTE_W-1:0] data;
    logic ctrl;
    logic force_disp;
    logic disp_val;
    logic compliance;
  } ppe_tx_s;

  typedef struct packed {
    logic [`PPE_BYTE_W-1:0] data;
    logic ctrl;
    logic code_err;
    logic disp_err;
  } ppe_rx_s;

endpackage

// ===== src/ppe_slipper.sv
/*
  Transmit bit slip and polarity inversion stage in front of the serializer.
  Assumes a synced reset; slip select changes between words only.
*/
`include "ppe_params.svh"

module ppe_slipper (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [`PPE_WORD_W-1:0] word_in,
  input wire logic [`PPE_SLIP_W-1:0] slip_in,
  input wire logic invert_in,
  input wire logic idle_in,
  output logic [`PPE_WORD_W-1:0] word_out
);
  import ppe_pkg::*;

  logic [`PPE_WORD_W-1:0] prev_reg;
  logic [`PPE_WORD_W-1:0] out_reg;
  logic [2*`PPE_WORD_W-1:0] pair;
  wire [`PPE_SLIP_W-1:0] slip_lim = (slip_in > `PPE_SLIP_MAX) ? `PPE_SLIP_MAX : slip_in;
  // slip advances the stream by n bits against slip 0, using the previous word's tail
  assign pair = {word_in, prev_reg} >> slip_lim;
  wire [`PPE_WORD_W-1:0] slipped = pair[`PPE_WORD_W-1:0];
  wire [`PPE_WORD_W-1:0] polar = invert_in ? ~slipped : slipped;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_reg <= `PPE_IDLE_WORD;
      out_reg <= `PPE_IDLE_WORD;
    end else begin
      prev_reg <= word_in;
      out_reg <= idle_in ? `PPE_IDLE_WORD : polar;
    end
  end

  assign word_out = out_reg;
endmodule

// ===== verification/pipe_phy_encoder_control_tb_top.sv
/*
  Self-checking bench for the PHY control block: power states, receiver
  detect, loopback, encoder controls, slip, idle and receive status.
  Assumes ppe_params.svh on the include path and the package compiled first.
*/
`include "ppe_params.svh"

module pipe_phy_encoder_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import ppe_pkg::*;

  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  ppe_tx_s tx_in = '0;
  logic [3:0] tx_slip_in = '0;
  logic tx_invert_in = 1'b0;
  logic pcie_mode_in = 1'b0;
  logic receive_polarity_invert_in = 1'b0;
  logic [1:0] power_state_in = `PPE_PD_P2;
  logic force_idle_in = 1'b1;
  logic infer_en_in = 1'b0;
  logic infer_idle_in = 1'b0;
  logic signal_detect_in = 1'b1;
  logic rx_present_in = 1'b0;
  logic [9:0] rx_word_in = '0;
  ppe_rx_s rx_dec_in = '0;
  logic rx_dec_valid_in = 1'b0;
  logic [3:0] ev_in = '0;
  logic [3:0] reconfig_cmd_in = '0;
  logic req = 1'b0;
  logic detect_loop;
  logic [9:0] tx_word_out;
  logic [9:0] rx_dec_word_out;
  logic [3:0] reconfig_out;
  logic tx_elec_idle_out, rx_detect_active_out, loopback_out, offset_cal_fixed_out;
  logic rx_elec_idle_out, phy_status_out, rx_valid_out;
  ppe_rxstat_t rx_status_out;
  ppe_rx_s rx_data_out;
  int error_cnt = 0;
  int num_checks = 0;

  always #20 clk_sys_in = ~clk_sys_in;

  ppe_mac_model ppe_mac_model_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .req_in(req),
    .phy_status_in(phy_status_out), .detect_loop_out(detect_loop));

  ppe_phy_ctrl ppe_phy_ctrl_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .tx_in(tx_in),
    .tx_slip_in(tx_slip_in), .tx_invert_in(tx_invert_in), .pcie_mode_in(pcie_mode_in),
    .receive_polarity_invert_in(receive_polarity_invert_in), .power_state_in(power_state_in),
    .detect_loop_in(detect_loop), .force_idle_in(force_idle_in), .infer_en_in(infer_en_in),
    .infer_idle_in(infer_idle_in), .signal_detect_in(signal_detect_in), .rx_present_in(rx_present_in),
    .rx_word_in(rx_word_in), .rx_dec_in(rx_dec_in), .rx_dec_valid_in(rx_dec_valid_in),
    .skip_add_in(ev_in[0]), .skip_del_in(ev_in[1]), .ebuf_ovfl_in(ev_in[2]), .ebuf_unfl_in(ev_in[3]),
    .reconfig_cmd_in(reconfig_cmd_in), .tx_word_out(tx_word_out), .tx_elec_idle_out(tx_elec_idle_out),
    .rx_detect_active_out(rx_detect_active_out), .loopback_out(loopback_out),
    .rx_dec_word_out(rx_dec_word_out), .offset_cal_fixed_out(offset_cal_fixed_out),
    .reconfig_out(reconfig_out), .rx_elec_idle_out(rx_elec_idle_out), .phy_status_out(phy_status_out),
    .rx_status_out(rx_status_out), .rx_data_out(rx_data_out), .rx_valid_out(rx_valid_out));

  task automatic results();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic ck(input bit ok, input string m);
    num_checks++;
    if (!ok) begin
      error_cnt++;
      $display("ERROR at %0t: %s", $time, m);
    end
  endtask

  task automatic edges(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic wait_phy();
    int i;
    i = 0;
    while (phy_status_out !== 1'b1 && i < 80) begin
      edges(1);
      i++;
    end
    ck(i < 80, "phy status never pulsed");
    edges(1);
    ck(phy_status_out === 1'b0, "phy status wider than one cycle");
  endtask

  task automatic t_power();
    logic [1:0] seq [4] = '{`PPE_PD_P0, `PPE_PD_P0S, `PPE_PD_P2, `PPE_PD_P1};
    foreach (seq[i]) begin
      @(posedge clk_sys_in);
      power_state_in <= seq[i];
      wait_phy();
    end
  endtask

  task automatic t_detect();
    @(posedge clk_sys_in);
    rx_present_in <= 1'b1;
    req <= 1'b1;
    edges(3);
    ck(rx_detect_active_out === 1'b1, "detect did not start");
    wait_phy();
    ck(rx_status_out === `PPE_RS_RX_DET, "receiver not reported");
    @(posedge clk_sys_in);
    req <= 1'b0;
    edges(3);
    ck(rx_status_out === `PPE_RS_OK && rx_detect_active_out === 1'b0, "detect status stuck");
  endtask

  task automatic t_loop();
    @(posedge clk_sys_in);
    power_state_in <= `PPE_PD_P0;
    wait_phy();
    @(posedge clk_sys_in);
    force_idle_in <= 1'b0;
    req <= 1'b1;
    edges(3);
    ck(loopback_out === 1'b1, "loopback not selected");
    @(posedge clk_sys_in);
    req <= 1'b0;
    edges(3);
    ck(loopback_out === 1'b0, "loopback stuck");
  endtask

  task automatic tx_get(input ppe_tx_s t, input logic [3:0] s, input logic inv, output logic [9:0] w);
    @(posedge clk_sys_in);
    tx_in <= t;
    tx_slip_in <= s;
    tx_invert_in <= inv;
    edges(5);
    w = tx_word_out;
  endtask

  task automatic t_tx();
    ppe_tx_s k;
    logic [9:0] wn, w;
    k = '{data: `PPE_K28_5, ctrl: 1'b1, force_disp: 1'b1, disp_val: 1'b1, compliance: 1'b0};
    tx_get(k, 4'h0, 1'b0, wn);
    ck(wn === 10'h0FA, "control group from negative start wrong");
    // forced words left running disparity positive; compliance must override it
    k.force_disp = 1'b0;
    k.compliance = 1'b1;
    @(posedge clk_sys_in);
    tx_in <= k;
    k.compliance = 1'b0;
    @(posedge clk_sys_in);
    tx_in <= k;
    edges(2);
    ck(tx_word_out === wn, "compliance not negative");
    edges(1);
    ck(tx_word_out === ~wn, "running disparity not alternating");
    k.force_disp = 1'b1;
    k.disp_val = 1'b0;
    tx_get(k, 4'h0, 1'b0, w);
    ck(w === ~wn, "forced positive start wrong");
    k.disp_val = 1'b1;
    k.ctrl = 1'b0;
    tx_get(k, 4'h0, 1'b0, w);
    ck(w === 10'h0EA, "data group wrong");
    k.ctrl = 1'b1;
    tx_get(k, 4'h0, 1'b1, w);
    ck(w === ~wn, "transmit inversion wrong");
    tx_get(k, 4'h3, 1'b0, w);
    ck(w === {wn[6:0], wn[9:7]} || w === {wn[2:0], wn[9:3]}, "slip by three wrong");
    @(posedge clk_sys_in);
    force_idle_in <= 1'b1;
    edges(4);
    ck(tx_elec_idle_out === 1'b1 && tx_word_out === `PPE_IDLE_WORD, "idle not driven");
  endtask

  task automatic t_rx();
    ppe_rxstat_t exp [6] = '{`PPE_RS_SKP_ADD, `PPE_RS_SKP_DEL, `PPE_RS_OVFL, `PPE_RS_UNFL,
      `PPE_RS_DEC_ERR, `PPE_RS_DISP_ERR};
    ppe_rx_s r;
    @(posedge clk_sys_in);
    pcie_mode_in <= 1'b1;
    receive_polarity_invert_in <= 1'b1;
    rx_word_in <= 10'h2C5;
    reconfig_cmd_in <= 4'hA;
    edges(3);
    ck(rx_dec_word_out === ~10'h2C5, "receive inversion wrong");
    ck(offset_cal_fixed_out === 1'b1 && reconfig_out === 4'hA, "pcie clocking or bus wrong");
    @(posedge clk_sys_in);
    pcie_mode_in <= 1'b0;
    edges(3);
    ck(rx_dec_word_out === 10'h2C5 && offset_cal_fixed_out === 1'b0, "non-pcie path wrong");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_in);
      infer_en_in <= i[1];
      signal_detect_in <= i[0];
      infer_idle_in <= i[0];
      edges(3);
      ck(rx_elec_idle_out === (i[1] ? i[0] : !i[0]), "idle indication wrong");
    end
    r = '{data: 8'h5A, ctrl: 1'b1, code_err: 1'b0, disp_err: 1'b0};
    @(posedge clk_sys_in);
    rx_dec_in <= r;
    rx_dec_valid_in <= 1'b1;
    edges(3);
    ck(rx_valid_out === 1'b1 && rx_data_out === r, "valid data wrong");
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys_in);
      ev_in <= (i < 4) ? 4'h1 << i : 4'h0;
      rx_dec_in <= '{data: 8'h5A, ctrl: 1'b1, code_err: i == 4, disp_err: i == 5};
      @(posedge clk_sys_in);
      ev_in <= 4'h0;
      rx_dec_in <= r;
      #1;
      ck(rx_status_out === exp[i], "receive status code wrong");
    end
    @(posedge clk_sys_in);
    rx_dec_valid_in <= 1'b0;
    edges(3);
    ck(rx_valid_out === 1'b0 && rx_status_out === `PPE_RS_OK, "valid or status stuck");
  endtask

  initial begin
    edges(11);
    ck(tx_elec_idle_out === 1'b1 && rx_elec_idle_out === 1'b1 && phy_status_out === 1'b0, "reset values");
    @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    edges(3);
    t_power();
    t_detect();
    t_loop();
    t_tx();
    t_rx();
    results();
  end
endmodule

// ===== verification/ppe_mac_model.sv
/*
  Behavioural model of the controlling logic on the PIPE side: owns the
  detect/loopback control and lets it go once PHY status reports.
  Assumes one clock shared with the block and a request level from the bench.
*/
module ppe_mac_model (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic req_in,
  input wire logic phy_status_in,
  output logic detect_loop_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic req_reg;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_reg <= 1'b0;
      detect_loop_out <= 1'b0;
    end else begin
      req_reg <= req_in;
      // completion ends detection at once; a held request must not restart it
      if (phy_status_in || !req_in) begin
        detect_loop_out <= 1'b0;
      end else if (req_in && !req_reg) begin
        detect_loop_out <= 1'b1;
      end
    end
  end
endmodule
